// >>> common/msm_pkg.sv
package msm_pkg;
  localparam int NUM_MIX = 2;
  localparam int MOD_W = 8;
  localparam int WIDE_W = 24;
  localparam int SM_W = 16;
  localparam int FRAC_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic signed [WIDE_W-1:0] msm_wide_t;

  // value ranges and arithmetic constants
  localparam msm_wide_t MOD_LIM = 24'sh000063;
  localparam msm_wide_t OFS_LIM = 24'sh0000C7;
  localparam msm_wide_t SLEW_LIM = 24'sh000063;
  localparam msm_wide_t SLEW_DIV = 24'sh000064;
  localparam msm_wide_t STEP_MIN = 24'sh000002;
  localparam msm_wide_t STEP_MAX = 24'sh000020;
  localparam msm_wide_t ASYM_SPAN = 24'sh0000C6;
  localparam msm_wide_t SYM_DIV = 24'sh002649;
  localparam msm_wide_t ASYM_DIV = 24'sh004C92;
  localparam msm_wide_t ONE_W = 24'sh000001;

  // register map, byte offsets inside one mixer window
  localparam int MIX_SEL_BIT = 5;
  localparam int REG_LSB = 2;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_GAIN_A = 5'h04;
  localparam logic [4:0] OFS_GAIN_B = 5'h08;
  localparam logic [4:0] OFS_OFFSET = 5'h0C;
  localparam logic [4:0] OFS_SLEW = 5'h10;
  localparam logic [4:0] OFS_SHAPE = 5'h14;
  localparam logic [4:0] OFS_STEPS = 5'h18;
  localparam logic [4:0] OFS_OUT = 5'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h40;

  // field positions
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_ASYM_BIT = 3;
  localparam int CTRL_CHAIN_BIT = 4;
  localparam int SLEW_FALL_LSB = 8;

  // reset values
  localparam logic [5:0] RST_STEPS = 6'h02;

  typedef enum logic [2:0] {
    TYPE_SUM,
    TYPE_SCALED_PRODUCT,
    TYPE_OFFSET,
    TYPE_SMOOTHING,
    TYPE_SHAPE,
    TYPE_QUANTIZE,
    TYPE_GATE
  } msm_type_e;

  function automatic msm_wide_t msm_clamp(input msm_wide_t v, input msm_wide_t lim);
    msm_wide_t r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r;
  endfunction : msm_clamp

  function automatic logic signed [MOD_W-1:0] msm_sat(input msm_wide_t v);
    return MOD_W'(msm_clamp(v, MOD_LIM));
  endfunction : msm_sat
endpackage : msm_pkg

// >>> common/msm_quant_if.sv
`timescale 1ns/1ns
`default_nettype none
interface msm_quant_if;
  import msm_pkg::*;
  logic signed [MOD_W-1:0] value;
  logic [5:0] steps;
  logic signed [MOD_W-1:0] level;
  modport user (output value, output steps, input level);
  modport quant (input value, input steps, output level);
endinterface : msm_quant_if
`default_nettype wire

// >>> rtl/msm_quant.sv
`timescale 1ns/1ns
`default_nettype none
module msm_quant
  import msm_pkg::*;
(
  // value in, level out
  msm_quant_if.quant q
);
  msm_wide_t v;
  msm_wide_t mag;
  msm_wide_t req;
  msm_wide_t n;
  msm_wide_t k;
  msm_wide_t lvl;

  assign v = msm_wide_t'(q.value);
  assign mag = msm_clamp((v < 0) ? -v : v, MOD_LIM);
  assign req = msm_wide_t'(q.steps);
  // step count held to 2..32
  assign n = (req < STEP_MIN) ? STEP_MIN : ((req > STEP_MAX) ? STEP_MAX : req);
  // level index, then level rounded up to k*99/n
  assign k = (mag * n) / MOD_LIM;
  assign lvl = (k * MOD_LIM + n - ONE_W) / n;
  assign q.level = MOD_W'((v < 0) ? -lvl : lvl);
endmodule : msm_quant
`default_nettype wire

// >>> rtl/msm_top.sv
// Functional notes
// - sum mode adds both scaled inputs
// - input gains signed -99..+99, sign sets polarity
// - product mode: second input steers first's gain
// - gain equals base plus second times amount
// - offset mode: first times gain plus offset
// - offset gain spans -199..+199
// - wide intermediates, clip only at output
// - offset setting spans up to +199
// - separate rise and fall slew settings
// - rise setting 0..99, larger is slower
// - fall setting 0..99, larger is slower
// - shape curvature signed -99..+99
// - shape is a static value mapping
// - asymmetric: one curve across full range
// - symmetric: mirrored curves from zero
// - quantize snaps to discrete levels
// - step count 2..32
// - positive levels multiples of 99/N
// - negative levels mirror positive ones
// - type selector chooses processing
// - first mixer output feeds second mixer
`timescale 1ns/1ns
`default_nettype none
module msm_top
  import msm_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [DATA_W-1:0] I_PWDATA,
  output logic [DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // modulation sources
  input wire logic [NUM_MIX-1:0][MOD_W-1:0] I_FIRST_MOD_INPUT,
  input wire logic [NUM_MIX-1:0][MOD_W-1:0] I_SECOND_MOD_INPUT,
  input wire logic I_UPDATE,
  input wire logic I_VOICE_RESET,
  // processed modulation
  output logic [NUM_MIX-1:0][MOD_W-1:0] O_MOD_OUT,
  output logic O_OUT_VALID
);
  typedef struct packed {
    logic [NUM_MIX-1:0][2:0] mtype;
    logic [NUM_MIX-1:0] asym;
    logic [NUM_MIX-1:0] chain;
    logic [NUM_MIX-1:0][8:0] gain_a;
    logic [NUM_MIX-1:0][7:0] gain_b;
    logic [NUM_MIX-1:0][8:0] offset;
    logic [NUM_MIX-1:0][6:0] rise;
    logic [NUM_MIX-1:0][6:0] fall;
    logic [NUM_MIX-1:0][7:0] shape;
    logic [NUM_MIX-1:0][5:0] steps;
    logic [NUM_MIX-1:0][MOD_W-1:0] out;
    logic [NUM_MIX-1:0][SM_W-1:0] smooth;
    logic [NUM_MIX-1:0] clip;
    logic valid;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } msm_state_s;

  msm_state_s st_reg;
  msm_state_s st_next;

  logic [NUM_MIX-1:0][MOD_W-1:0] mix_res;
  logic [NUM_MIX-1:0][SM_W-1:0] smooth_nx;
  logic [NUM_MIX-1:0][SM_W-1:0] smooth_init;
  logic [NUM_MIX-1:0] clip_hit;

  genvar m;
  generate
    for (m = 0; m < NUM_MIX; m++) begin : g_mix
      localparam int PREV = (m == 0) ? 0 : m - 1;
      logic signed [MOD_W-1:0] a_in;
      msm_type_e ty;
      msm_wide_t a_w;
      msm_wide_t b_w;
      msm_wide_t ga;
      msm_wide_t gb;
      msm_wide_t ofs;
      msm_wide_t rise;
      msm_wide_t fall;
      msm_wide_t shp;
      msm_wide_t pgain;
      msm_wide_t mag;
      msm_wide_t pos;
      msm_wide_t sym_y;
      msm_wide_t asym_y;
      msm_wide_t sm;
      msm_wide_t tgt;
      msm_wide_t sdiff;
      msm_wide_t coef;
      msm_wide_t snext;
      msm_wide_t res;
      msm_wide_t a_raw;
      msm_wide_t sum_y;
      msm_wide_t prod_y;
      msm_wide_t ofs_y;
      msm_wide_t slew_y;
      msm_wide_t shape_y;
      msm_wide_t quant_y;
      msm_quant_if qif ();

      assign ty = msm_type_e'(st_reg.mtype[m]);
      // second mixer may take the first mixer's last output,
      // so a chain adds one tick of latency
      assign a_in = (m > 0 && st_reg.chain[m]) ? st_reg.out[PREV] : I_FIRST_MOD_INPUT[m];
      // sources beyond the legal span are held to it before any math
      assign a_raw = msm_wide_t'(a_in);
      assign a_w = msm_clamp(a_raw, MOD_LIM);
      assign b_w = msm_clamp(msm_wide_t'($signed(I_SECOND_MOD_INPUT[m])), MOD_LIM);

      // gain ranges depend on type
      assign ga = msm_clamp(msm_wide_t'($signed(st_reg.gain_a[m])),
                            (ty == TYPE_OFFSET) ? OFS_LIM : MOD_LIM);
      assign gb = msm_clamp(msm_wide_t'($signed(st_reg.gain_b[m])), MOD_LIM);
      assign ofs = msm_clamp(msm_wide_t'($signed(st_reg.offset[m])), OFS_LIM);
      assign rise = msm_clamp(msm_wide_t'(st_reg.rise[m]), SLEW_LIM);
      assign fall = msm_clamp(msm_wide_t'(st_reg.fall[m]), SLEW_LIM);
      assign shp = msm_clamp(msm_wide_t'($signed(st_reg.shape[m])), MOD_LIM);

      // effective gain of first input in product mode
      assign pgain = msm_clamp(ga + (b_w * gb) / MOD_LIM, MOD_LIM);

      // symmetric curve on magnitude, sign restored
      assign mag = (a_w < 0) ? -a_w : a_w;
      assign sym_y = mag + (shp * mag * (MOD_LIM - mag)) / SYM_DIV;
      // asymmetric curve over the whole span
      assign pos = a_w + MOD_LIM;
      assign asym_y = pos + (shp * pos * (ASYM_SPAN - pos)) / ASYM_DIV - MOD_LIM;

      // one-pole slew in fixed point, rate by direction
      assign sm = msm_wide_t'($signed(st_reg.smooth[m]));
      assign tgt = a_w <<< FRAC_W;
      assign sdiff = tgt - sm;
      assign coef = SLEW_DIV - ((sdiff > 0) ? rise : fall);
      assign snext = sm + (sdiff * coef) / SLEW_DIV;

      assign qif.value = a_in;
      assign qif.steps = st_reg.steps[m];

      msm_quant u_quant (
        .q(qif)
      );

      // one candidate per type, the selector below picks one
      assign sum_y = (a_w * ga + b_w * gb) / MOD_LIM;
      assign prod_y = (a_w * pgain) / MOD_LIM;
      // offset result stays wide here, clipped only at the output
      assign ofs_y = (a_w * ga) / MOD_LIM + ofs;
      assign slew_y = snext >>> FRAC_W;
      // pure function of the present input value
      assign shape_y = st_reg.asym[m] ? asym_y : ((a_w < 0) ? -sym_y : sym_y);
      assign quant_y = msm_wide_t'(qif.level);

      always_comb begin
        case (ty)
          TYPE_SUM: begin
            res = sum_y;
          end
          TYPE_SCALED_PRODUCT: begin
            res = prod_y;
          end
          TYPE_OFFSET: begin
            res = ofs_y;
          end
          TYPE_SMOOTHING: begin
            res = slew_y;
          end
          TYPE_SHAPE: begin
            res = shape_y;
          end
          TYPE_QUANTIZE: begin
            res = quant_y;
          end
          TYPE_GATE: begin
            // gate control is not built: the first input passes
            res = a_w;
          end
          default: begin
            res = a_w;
          end
        endcase
      end

      assign mix_res[m] = msm_sat(res);
      // flags any result beyond the legal span
      assign clip_hit[m] = (res > MOD_LIM) || (res < -MOD_LIM);
      assign smooth_nx[m] = SM_W'(snext);
      assign smooth_init[m] = SM_W'(tgt);
    end
  endgenerate

  // apb decode
  logic access;
  logic setup;
  logic sel;
  logic [4:0] reg_ofs;
  logic win_ok;
  logic stat_hit;
  logic addr_ok;
  logic wr_err;
  logic hi_zero;
  logic aligned;
  logic wr_win;
  logic wr_stat;
  logic [DATA_W-1:0] rdata;

  assign access = I_PSEL && I_PENABLE;
  assign setup = I_PSEL && !I_PENABLE;
  assign sel = I_PADDR[MIX_SEL_BIT];
  assign reg_ofs = I_PADDR[4:0];
  // only the two mixer windows, word aligned, and the status word decode
  assign hi_zero = (I_PADDR[ADDR_W-1:MIX_SEL_BIT+1] == '0);
  assign aligned = (I_PADDR[REG_LSB-1:0] == '0);
  assign win_ok = hi_zero && aligned;
  assign stat_hit = (I_PADDR == ADDR_STATUS);
  assign addr_ok = win_ok || stat_hit;
  assign wr_err = I_PWRITE && win_ok && (reg_ofs == OFS_OUT);
  assign wr_win = access && I_PWRITE && win_ok;
  assign wr_stat = access && I_PWRITE && stat_hit;

  // unused bits and unmapped words read as zero
  always_comb begin
    rdata = '0;
    if (stat_hit) begin
      rdata = DATA_W'(st_reg.clip);
    end else if (win_ok) begin
      case (reg_ofs)
        OFS_CTRL: begin
          rdata = DATA_W'({st_reg.chain[sel], st_reg.asym[sel], st_reg.mtype[sel]});
        end
        OFS_GAIN_A: begin
          rdata = DATA_W'(st_reg.gain_a[sel]);
        end
        OFS_GAIN_B: begin
          rdata = DATA_W'(st_reg.gain_b[sel]);
        end
        OFS_OFFSET: begin
          rdata = DATA_W'(st_reg.offset[sel]);
        end
        OFS_SLEW: begin
          rdata = DATA_W'({1'b0, st_reg.fall[sel], 1'b0, st_reg.rise[sel]});
        end
        OFS_SHAPE: begin
          rdata = DATA_W'(st_reg.shape[sel]);
        end
        OFS_STEPS: begin
          rdata = DATA_W'(st_reg.steps[sel]);
        end
        OFS_OUT: begin
          rdata = DATA_W'(st_reg.out[sel]);
        end
        default: begin
          rdata = '0;
        end
      endcase
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    // read data and error captured in setup phase;
    // a write in the same transfer's access phase shows on a later read
    if (setup) begin
      st_next.prdata = rdata;
      st_next.pslverr = !addr_ok || wr_err;
    end
    if (wr_win) begin
      case (reg_ofs)
        OFS_CTRL: begin
          st_next.mtype[sel] = I_PWDATA[CTRL_TYPE_LSB +: 3];
          st_next.asym[sel] = I_PWDATA[CTRL_ASYM_BIT];
          st_next.chain[sel] = I_PWDATA[CTRL_CHAIN_BIT];
        end
        OFS_GAIN_A: begin
          st_next.gain_a[sel] = I_PWDATA[8:0];
        end
        OFS_GAIN_B: begin
          st_next.gain_b[sel] = I_PWDATA[7:0];
        end
        OFS_OFFSET: begin
          st_next.offset[sel] = I_PWDATA[8:0];
        end
        OFS_SLEW: begin
          st_next.rise[sel] = I_PWDATA[6:0];
          st_next.fall[sel] = I_PWDATA[SLEW_FALL_LSB +: 7];
        end
        OFS_SHAPE: begin
          st_next.shape[sel] = I_PWDATA[7:0];
        end
        OFS_STEPS: begin
          st_next.steps[sel] = I_PWDATA[5:0];
        end
        default: begin
        end
      endcase
    end
    // clip flags: write one clears
    if (wr_stat) begin
      st_next.clip = st_reg.clip & ~I_PWDATA[NUM_MIX-1:0];
    end
    // new results once per update tick
    // settings written between ticks take effect at the next one
    if (I_UPDATE) begin
      st_next.out = mix_res;
      st_next.smooth = smooth_nx;
      st_next.valid = 1'b1;
      // a clip in the same cycle as its clear still sets
      st_next.clip = st_next.clip | clip_hit;
    end
    // the smoother runs on every tick whatever the type
    // voice reset snaps the smoother to its input
    if (I_VOICE_RESET) begin
      st_next.smooth = smooth_init;
    end
  end

  // reset: sum type, zero gains, coarsest quantize step count
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_reg <= '0;
      st_reg.steps <= {NUM_MIX{RST_STEPS}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_PRDATA = st_reg.prdata;
  assign O_PSLVERR = st_reg.pslverr;
  // no wait states: ready in the first access cycle
  assign O_PREADY = access;
  assign O_MOD_OUT = st_reg.out;
  assign O_OUT_VALID = st_reg.valid;
endmodule : msm_top
`default_nettype wire

// >>> dv/msm_properties.sv
`timescale 1ns/1ns
`default_nettype none
module msm_properties
  import msm_pkg::*;
(
  // clock, reset, bus
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [DATA_W-1:0] I_PWDATA,
  input wire logic O_PREADY,
  // modulation
  input wire logic [NUM_MIX-1:0][MOD_W-1:0] I_FIRST_MOD_INPUT,
  input wire logic [NUM_MIX-1:0][MOD_W-1:0] I_SECOND_MOD_INPUT,
  input wire logic I_UPDATE,
  input wire logic [NUM_MIX-1:0][MOD_W-1:0] O_MOD_OUT,
  input wire logic O_OUT_VALID
);
  logic [2:0] type_reg;
  // mirror of mixer0 type field
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      type_reg <= 3'h0;
    end else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h00) begin
      type_reg <= I_PWDATA[2:0];
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_ready; O_PREADY == (I_PSEL && I_PENABLE); endproperty
  property p_valid; I_UPDATE |=> O_OUT_VALID; endproperty
  property p_quiet; !I_UPDATE |=> !O_OUT_VALID && $stable(O_MOD_OUT); endproperty
  property p_rng0; O_OUT_VALID |-> $signed(O_MOD_OUT[0]) <= 99 && $signed(O_MOD_OUT[0]) >= -99;
  endproperty
  property p_rng1; O_OUT_VALID |-> $signed(O_MOD_OUT[1]) <= 99 && $signed(O_MOD_OUT[1]) >= -99;
  endproperty
  property p_sum0; type_reg == 3'h0 && I_UPDATE && I_FIRST_MOD_INPUT[0] == 8'h00
    && I_SECOND_MOD_INPUT[0] == 8'h00 |=> O_MOD_OUT[0] == 8'h00; endproperty
  property p_shape; type_reg == 3'h4 && I_UPDATE && I_FIRST_MOD_INPUT[0] == 8'h63
    |=> O_MOD_OUT[0] == 8'h63; endproperty
  property p_quant; type_reg == 3'h5 && I_UPDATE && I_FIRST_MOD_INPUT[0] == 8'h9D
    |=> O_MOD_OUT[0] == 8'h9D; endproperty
  a_ready: assert property (p_ready) else $error("pready mismatch");
  a_valid: assert property (p_valid) else $error("no valid after update");
  a_quiet: assert property (p_quiet) else $error("output moved without update");
  a_rng0: assert property (p_rng0) else $error("mixer0 out of range");
  a_rng1: assert property (p_rng1) else $error("mixer1 out of range");
  a_sum0: assert property (p_sum0) else $error("sum of zeros not zero");
  a_shape: assert property (p_shape) else $error("shape end point moved");
  a_quant: assert property (p_quant) else $error("lowest level wrong");
  c_upd: cover property (I_UPDATE ##1 O_OUT_VALID);
  c_shape: cover property (type_reg == 3'h4 && I_UPDATE);
  c_quant: cover property (type_reg == 3'h5 && I_UPDATE);
endmodule : msm_properties
`default_nettype wire

// >>> dv/msm_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module msm_src_model
  import msm_pkg::*;
(
  input wire logic i_clk,
  output logic [NUM_MIX-1:0][MOD_W-1:0] o_first,
  output logic [NUM_MIX-1:0][MOD_W-1:0] o_second,
  output logic o_update,
  output logic o_voice_reset
);
  initial begin
    o_first = '0;
    o_second = '0;
    o_update = 1'b0;
    o_voice_reset = 1'b0;
  end
  // one sample per update tick, optional voice start first
  task automatic send(input logic [7:0] a, input logic [7:0] b, input logic vr);
    @(posedge i_clk);
    o_first <= {b, a};
    o_second <= {a, b};
    o_voice_reset <= vr;
    if (vr) begin
      @(posedge i_clk);
      o_voice_reset <= 1'b0;
    end
    o_update <= 1'b1;
    @(posedge i_clk);
    o_update <= 1'b0;
  endtask : send
endmodule : msm_src_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import msm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, upd_p, vrst, oval;
  logic [NUM_MIX-1:0][MOD_W-1:0] fa, sb, mout;
  int err_count = 0;
  int comparisons = 0;
  msm_top dut_u (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_FIRST_MOD_INPUT(fa), .I_SECOND_MOD_INPUT(sb), .I_UPDATE(upd_p),
    .I_VOICE_RESET(vrst), .O_MOD_OUT(mout), .O_OUT_VALID(oval));
  msm_src_model src_u (.i_clk(clk), .o_first(fa), .o_second(sb), .o_update(upd_p),
    .o_voice_reset(vrst));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // wait states are the slave's; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ad, d, r, e);
  endtask : wr
  // one update, then judge mixer0
  task automatic upd(input logic [7:0] a, input logic [7:0] e, input logic vr = 1'b0,
                     input logic [7:0] b = 8'h00);
    src_u.send(a, b, vr);
    // judged mid-cycle while the new output stands
    while (oval !== 1'b1) begin
      @(negedge clk);
    end
    cmp({24'h0, e}, {24'h0, mout[0]});
  endtask : upd
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h18, 32'h0, r, e);
    cmp(32'h2, r);
    apb(1'b0, 8'h44, 32'h0, r, e);
    cmp(32'h1, {31'h0, e});
    apb(1'b1, 8'h1C, 32'h5, r, e);
    cmp(32'h1, {31'h0, e});
    $display("done regs");
  endtask : t_regs
  task automatic t_mix;
    logic [31:0] r;
    logic e;
    wr(8'h04, 32'h63);
    wr(8'h08, 32'h9D);
    upd(8'h00, 8'h00);
    upd(8'h32, 8'h14, 1'b0, 8'h1E);
    wr(8'h08, 32'h63);
    upd(8'h63, 8'h63, 1'b0, 8'h63);
    apb(1'b0, 8'h40, 32'h0, r, e);
    cmp(32'h1, r);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    upd(8'h3C, 8'h3C, 1'b0, 8'h63);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h63);
    wr(8'h0C, 32'hC7);
    upd(8'h9D, 8'h63);
    wr(8'h04, 32'hC7);
    wr(8'h0C, 32'h16A);
    upd(8'h63, 8'h31);
    wr(8'h04, 32'h139);
    wr(8'h0C, 32'h0);
    upd(8'hD8, 8'h50);
    $display("done mix");
  endtask : t_mix
  task automatic t_smooth;
    wr(8'h00, 32'h3);
    wr(8'h10, 32'h63);
    upd(8'h00, 8'h00, 1'b1);
    upd(8'h63, 8'h00);
    upd(8'hCE, 8'hCE);
    upd(8'h46, 8'h46, 1'b1);
    $display("done smooth");
  endtask : t_smooth
  task automatic t_shape;
    wr(8'h00, 32'h4);
    wr(8'h14, 32'h63);
    upd(8'h32, 8'h4A);
    upd(8'hCE, 8'hB6);
    wr(8'h00, 32'hC);
    upd(8'h00, 8'h31);
    upd(8'h32, 8'h56);
    upd(8'h63, 8'h63);
    upd(8'h9D, 8'h9D);
    upd(8'h00, 8'h31);
    $display("done shape");
  endtask : t_shape
  task automatic t_quant;
    wr(8'h00, 32'h5);
    upd(8'h3C, 8'h32);
    upd(8'h1E, 8'h00);
    upd(8'h9D, 8'h9D);
    wr(8'h18, 32'h5);
    upd(8'h2D, 8'h28);
    $display("done quant");
  endtask : t_quant
  task automatic t_chain;
    wr(8'h00, 32'h6);
    wr(8'h20, 32'h10);
    wr(8'h24, 32'h63);
    upd(8'h28, 8'h28);
    upd(8'hEC, 8'hEC);
    cmp(32'h28, {24'h0, mout[1]});
    $display("done chain");
  endtask : t_chain
  task automatic end_sim;
    $display("compares %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_mix();
    t_smooth();
    t_shape();
    t_quant();
    t_chain();
    end_sim();
  end
endmodule : tb_top
bind msm_top msm_properties chk_u (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .I_FIRST_MOD_INPUT(I_FIRST_MOD_INPUT),
  .I_SECOND_MOD_INPUT(I_SECOND_MOD_INPUT), .I_UPDATE(I_UPDATE), .O_MOD_OUT(O_MOD_OUT),
  .O_OUT_VALID(O_OUT_VALID));
`default_nettype wire
